// [src/smr_config_regs.sv]
`timescale 1ns/1ns
module smr_config_regs
  import smr_pkg::*;
#(
  parameter int WDT_SHORT_CYCLES   = SMR_WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES    = SMR_WDT_LONG_CYC,
  parameter int SAMPLE_BASE_CYCLES = SMR_SAMPLE_BASE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire smr_req_s    req,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  input  wire smr_events_s events,
  input  wire logic        nvm_wdt_enable,
  input  wire logic        nvm_wdt_period,
  output logic             irq_pin_out,
  output logic             irq_pin_oe,
  output logic             irq_pad_strength_sel,
  output logic             three_wire_select,
  output logic             bus_watchdog_enable,
  output logic [31:0]      bus_watchdog_cycles,
  output logic             pressure_channel_on,
  output logic             temperature_channel_on,
  output smr_mode_e        meas_mode,
  output logic [5:0]       pressure_oversample,
  output logic [5:0]       temperature_oversample,
  output logic [4:0]       rate_divider_exponent,
  output logic [35:0]      sample_period_cycles,
  output logic [6:0]       smoothing_coefficient
);

  typedef struct packed {
    logic [7:0]  int_ctrl;
    logic [7:0]  if_setup;
    logic [7:0]  power_control;
    logic [7:0]  osr_setup;
    logic [7:0]  odr_setup;
    logic [7:0]  filt;
    logic [7:0]  flags;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        nvm_done;
    logic [31:0] wdt_cyc;
  } smr_state_s;

  smr_state_s st_r;
  smr_state_s st_nxt;
  logic [7:0] ev_vec;
  logic [7:0] flag_nxt;
  logic       flag_clr;
  logic       hold;
  logic [4:0] rate_wr;

  always_comb begin
    ev_vec = '0;
    ev_vec[SMR_FL_WM]   = events.fifo_watermark & st_r.int_ctrl[SMR_IC_WM_EN];
    ev_vec[SMR_FL_FULL] = events.fifo_full & st_r.int_ctrl[SMR_IC_FULL_EN];
    ev_vec[SMR_FL_DRDY] = events.data_ready & st_r.int_ctrl[SMR_IC_DRDY_EN];
  end

  assign hold     = st_r.int_ctrl[SMR_IC_HOLD];
  assign flag_clr = req.rd_en && (req.addr == SMR_ADDR_IRQ_FLAGS);

  // Flag update per bit; an event in the clearing cycle wins
  for (genvar i = 0; i < 8; i++) begin : g_flag
    always_comb begin
      if (!SMR_MASK_FLAGS[i]) begin
        flag_nxt[i] = 1'b0;
      end else if (hold) begin
        flag_nxt[i] = ev_vec[i] | (st_r.flags[i] & ~flag_clr);
      end else begin
        flag_nxt[i] = ev_vec[i];
      end
    end
  end

  assign rate_wr = (req.wdata[4:0] > SMR_RATE_EXP_MAX) ? SMR_RATE_EXP_MAX : req.wdata[4:0];

  always_comb begin
    st_nxt        = st_r;
    st_nxt.flags  = flag_nxt;
    st_nxt.rvalid = req.rd_en;
    st_nxt.rdata  = st_r.rdata;
    if (!st_r.nvm_done) begin
      st_nxt.nvm_done = 1'b1;
      st_nxt.if_setup[SMR_IF_WDT_EN]  = nvm_wdt_enable;
      st_nxt.if_setup[SMR_IF_WDT_SEL] = nvm_wdt_period;
    end
    if (req.wr_en) begin
      case (req.addr)
        SMR_ADDR_INT_CTRL:  st_nxt.int_ctrl  = req.wdata & SMR_MASK_INT_CTRL;
        SMR_ADDR_IF_SETUP:  st_nxt.if_setup  = req.wdata & SMR_MASK_IF_SETUP;
        SMR_ADDR_POWER_CONTROL:  st_nxt.power_control  = req.wdata & SMR_MASK_POWER_CONTROL;
        SMR_ADDR_OSR_SETUP: st_nxt.osr_setup = req.wdata & SMR_MASK_OSR_SETUP;
        SMR_ADDR_ODR_SETUP: st_nxt.odr_setup = {3'h0, rate_wr};
        SMR_ADDR_FILT:      st_nxt.filt      = req.wdata & SMR_MASK_FILT;
        default: ;
      endcase
    end
    if (req.rd_en) begin
      case (req.addr)
        SMR_ADDR_IRQ_FLAGS: st_nxt.rdata = st_r.flags;
        SMR_ADDR_INT_CTRL:  st_nxt.rdata = st_r.int_ctrl;
        SMR_ADDR_IF_SETUP:  st_nxt.rdata = st_r.if_setup;
        SMR_ADDR_POWER_CONTROL:  st_nxt.rdata = st_r.power_control;
        SMR_ADDR_OSR_SETUP: st_nxt.rdata = st_r.osr_setup;
        SMR_ADDR_ODR_SETUP: st_nxt.rdata = st_r.odr_setup;
        SMR_ADDR_FILT:      st_nxt.rdata = st_r.filt;
        default:            st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.wdt_cyc = st_nxt.if_setup[SMR_IF_WDT_SEL] ? 32'(WDT_LONG_CYCLES) : 32'(WDT_SHORT_CYCLES);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.int_ctrl  <= SMR_RST_INT_CTRL;
      st_r.if_setup  <= SMR_RST_IF_SETUP;
      st_r.power_control  <= SMR_RST_POWER_CONTROL;
      st_r.osr_setup <= SMR_RST_OSR_SETUP;
      st_r.odr_setup <= SMR_RST_ODR_SETUP;
      st_r.filt      <= SMR_RST_FILT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data                = st_r.rdata;
  assign rd_valid               = st_r.rvalid;
  assign irq_pad_strength_sel   = st_r.int_ctrl[SMR_IC_STRENGTH];
  assign three_wire_select      = st_r.if_setup[SMR_IF_THREE_WIRE];
  assign bus_watchdog_enable    = st_r.if_setup[SMR_IF_WDT_EN];
  assign bus_watchdog_cycles    = st_r.wdt_cyc;
  assign pressure_channel_on    = st_r.power_control[SMR_PC_PRESS_ON];
  assign temperature_channel_on = st_r.power_control[SMR_PC_TEMP_ON];
  assign rate_divider_exponent  = st_r.odr_setup[4:0];

  smr_irq_pin u_irq_pin (
    .sys_clk               (sys_clk),
    .rst_n                 (rst_n),
    .irq_active            (|st_r.flags),
    .irq_polarity          (st_r.int_ctrl[SMR_IC_POLARITY]),
    .irq_output_drive_type (st_r.int_ctrl[SMR_IC_DRIVE_TYPE]),
    .irq_pin_out           (irq_pin_out),
    .irq_pin_oe            (irq_pin_oe)
  );

  smr_cfg_decode #(
    .SAMPLE_BASE_CYCLES (SAMPLE_BASE_CYCLES)
  ) u_decode (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .power_control               (st_r.power_control),
    .osr_setup              (st_r.osr_setup),
    .odr_setup              (st_r.odr_setup),
    .filt_setup             (st_r.filt),
    .meas_mode              (meas_mode),
    .pressure_oversample    (pressure_oversample),
    .temperature_oversample (temperature_oversample),
    .sample_period_cycles   (sample_period_cycles),
    .smoothing_coefficient  (smoothing_coefficient)
  );

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_flag_read;
    req.rd_en && req.addr == SMR_ADDR_IRQ_FLAGS;
  endsequence

  sequence s_quiet_held_read;
    s_flag_read and (hold && ev_vec == 8'h00);
  endsequence

  a_wm_flag_set: assert property (
    events.fifo_watermark && st_r.int_ctrl[SMR_IC_WM_EN] |=> st_r.flags[SMR_FL_WM])
    else $error("watermark flag not set");

  a_wm_masked: assert property (
    !st_r.int_ctrl[SMR_IC_WM_EN] && !st_r.flags[SMR_FL_WM] |=> !st_r.flags[SMR_FL_WM])
    else $error("masked watermark flag set");

  a_full_flag_set: assert property (
    events.fifo_full && st_r.int_ctrl[SMR_IC_FULL_EN] |=> st_r.flags[SMR_FL_FULL])
    else $error("full flag not set");

  a_drdy_flag_set: assert property (
    events.data_ready && st_r.int_ctrl[SMR_IC_DRDY_EN] |=> st_r.flags[SMR_FL_DRDY])
    else $error("ready flag not set");

  a_hold_keeps_flag: assert property (
    hold && st_r.flags[SMR_FL_DRDY] && !flag_clr |=> st_r.flags[SMR_FL_DRDY])
    else $error("held flag dropped");

  a_nohold_follow: assert property (
    !hold && !ev_vec[SMR_FL_DRDY] |=> !st_r.flags[SMR_FL_DRDY])
    else $error("flag held without hold");

  a_read_clears: assert property (
    s_quiet_held_read ##0 (st_r.flags != 8'h00) |=> rd_valid && rd_data != 8'h00 && st_r.flags == 8'h00)
    else $error("flag read did not clear");

  a_rate_saturate: assert property (
    req.wr_en && req.addr == SMR_ADDR_ODR_SETUP && req.wdata[4:0] > SMR_RATE_EXP_MAX
    |=> rate_divider_exponent == SMR_RATE_EXP_MAX)
    else $error("rate exponent not saturated");

  a_pin_push_high: assert property (
    st_r.int_ctrl[1:0] == 2'b10 && st_r.flags != 8'h00 |=> irq_pin_out && irq_pin_oe)
    else $error("push-pull pin not high");

  a_pin_od_release: assert property (
    st_r.int_ctrl[SMR_IC_DRIVE_TYPE] && !st_r.int_ctrl[SMR_IC_POLARITY] && st_r.flags == 8'h00
    |=> !irq_pin_oe)
    else $error("open-drain pin not released");

  a_mode_normal: assert property (
    req.wr_en && req.addr == SMR_ADDR_POWER_CONTROL && req.wdata[5:4] == 2'b11
    |=> ##1 meas_mode == SMR_MODE_NORMAL)
    else $error("normal mode not decoded");

  a_full_masked: assert property (
    !st_r.int_ctrl[SMR_IC_FULL_EN] && !st_r.flags[SMR_FL_FULL] |=> !st_r.flags[SMR_FL_FULL])
    else $error("masked full flag set");

  a_drdy_masked: assert property (
    !st_r.int_ctrl[SMR_IC_DRDY_EN] && !st_r.flags[SMR_FL_DRDY] |=> !st_r.flags[SMR_FL_DRDY])
    else $error("masked ready flag set");

  a_rvalid_pulse: assert property (
    !req.rd_en |=> !rd_valid)
    else $error("read valid without read");

  a_pin_od_drive: assert property (
    st_r.int_ctrl[1:0] == 2'b01 && st_r.flags != 8'h00 |=> !irq_pin_out && irq_pin_oe)
    else $error("open-drain pin not pulled low");

  a_strength_store: assert property (
    req.wr_en && req.addr == SMR_ADDR_INT_CTRL && req.wdata[SMR_IC_STRENGTH] |=> irq_pad_strength_sel)
    else $error("strength bit not stored");

  a_three_wire: assert property (
    req.wr_en && req.addr == SMR_ADDR_IF_SETUP && req.wdata[SMR_IF_THREE_WIRE] |=> three_wire_select)
    else $error("three-wire bit not stored");

  a_wdt_enable: assert property (
    req.wr_en && req.addr == SMR_ADDR_IF_SETUP && req.wdata[SMR_IF_WDT_EN] |=> bus_watchdog_enable)
    else $error("watchdog enable not stored");

  a_wdt_long: assert property (
    req.wr_en && req.addr == SMR_ADDR_IF_SETUP && req.wdata[SMR_IF_WDT_SEL]
    |=> bus_watchdog_cycles == 32'(WDT_LONG_CYCLES))
    else $error("long watchdog period wrong");

  a_wdt_short: assert property (
    req.wr_en && req.addr == SMR_ADDR_IF_SETUP && !req.wdata[SMR_IF_WDT_SEL]
    |=> bus_watchdog_cycles == 32'(WDT_SHORT_CYCLES))
    else $error("short watchdog period wrong");

  a_press_on: assert property (
    req.wr_en && req.addr == SMR_ADDR_POWER_CONTROL && req.wdata[SMR_PC_PRESS_ON] |=> pressure_channel_on)
    else $error("pressure enable not stored");

  a_temp_on: assert property (
    req.wr_en && req.addr == SMR_ADDR_POWER_CONTROL && req.wdata[SMR_PC_TEMP_ON] |=> temperature_channel_on)
    else $error("temperature enable not stored");

  a_mode_sleep: assert property (
    req.wr_en && req.addr == SMR_ADDR_POWER_CONTROL && req.wdata[5:4] == 2'b00
    |=> ##1 meas_mode == SMR_MODE_SLEEP)
    else $error("sleep mode not decoded");

  a_mode_forced: assert property (
    req.wr_en && req.addr == SMR_ADDR_POWER_CONTROL && (req.wdata[5:4] == 2'b01 || req.wdata[5:4] == 2'b10)
    |=> ##1 meas_mode == SMR_MODE_FORCED)
    else $error("forced mode not decoded");

  a_os_clamp: assert property (
    req.wr_en && req.addr == SMR_ADDR_OSR_SETUP && req.wdata[2:0] > SMR_OSR_CODE_MAX
    |=> ##1 pressure_oversample == 6'h20)
    else $error("oversampling code not clamped");

  a_period_base: assert property (
    req.wr_en && req.addr == SMR_ADDR_ODR_SETUP && req.wdata[4:0] == 5'h00
    |=> ##1 sample_period_cycles == 36'(SAMPLE_BASE_CYCLES))
    else $error("base sample period wrong");

  a_filt_bypass: assert property (
    req.wr_en && req.addr == SMR_ADDR_FILT && req.wdata[3:1] == 3'h0
    |=> ##1 smoothing_coefficient == 7'h00)
    else $error("filter bypass not decoded");

endmodule // smr_config_regs

// [src/smr_pkg.sv]
package smr_pkg;

  // Register offsets
  localparam logic [7:0] SMR_ADDR_IRQ_FLAGS = 8'h11;
  localparam logic [7:0] SMR_ADDR_INT_CTRL  = 8'h19;
  localparam logic [7:0] SMR_ADDR_IF_SETUP  = 8'h1A;
  localparam logic [7:0] SMR_ADDR_POWER_CONTROL  = 8'h1B;
  localparam logic [7:0] SMR_ADDR_OSR_SETUP = 8'h1C;
  localparam logic [7:0] SMR_ADDR_ODR_SETUP = 8'h1D;
  localparam logic [7:0] SMR_ADDR_FILT      = 8'h1F;

  // Interrupt control fields
  localparam int unsigned SMR_IC_DRIVE_TYPE = 0;
  localparam int unsigned SMR_IC_POLARITY   = 1;
  localparam int unsigned SMR_IC_HOLD       = 2;
  localparam int unsigned SMR_IC_WM_EN      = 3;
  localparam int unsigned SMR_IC_FULL_EN    = 4;
  localparam int unsigned SMR_IC_STRENGTH   = 5;
  localparam int unsigned SMR_IC_DRDY_EN    = 6;
  // Interface setup fields
  localparam int unsigned SMR_IF_THREE_WIRE = 0;
  localparam int unsigned SMR_IF_WDT_EN     = 1;
  localparam int unsigned SMR_IF_WDT_SEL    = 2;
  // Power control fields
  localparam int unsigned SMR_PC_PRESS_ON   = 0;
  localparam int unsigned SMR_PC_TEMP_ON    = 1;
  localparam int unsigned SMR_PC_MODE_LO    = 4;
  // Oversampling and filter fields
  localparam int unsigned SMR_OS_PRESS_LO   = 0;
  localparam int unsigned SMR_OS_TEMP_LO    = 3;
  localparam int unsigned SMR_FC_COEF_LO    = 1;
  // Flag positions
  localparam int unsigned SMR_FL_WM         = 0;
  localparam int unsigned SMR_FL_FULL       = 1;
  localparam int unsigned SMR_FL_DRDY       = 3;

  // Writable bits and the flag bits that can set; the rest read as zero
  localparam logic [7:0] SMR_MASK_INT_CTRL  = 8'h7F;
  localparam logic [7:0] SMR_MASK_IF_SETUP  = 8'h07;
  localparam logic [7:0] SMR_MASK_POWER_CONTROL  = 8'h33;
  localparam logic [7:0] SMR_MASK_OSR_SETUP = 8'h3F;
  localparam logic [7:0] SMR_MASK_ODR_SETUP = 8'h1F;
  localparam logic [7:0] SMR_MASK_FILT      = 8'h0E;
  localparam logic [7:0] SMR_MASK_FLAGS     = 8'h0B;

  // Reset values
  localparam logic [7:0] SMR_RST_INT_CTRL   = 8'h00;
  localparam logic [7:0] SMR_RST_IF_SETUP   = 8'h00;
  localparam logic [7:0] SMR_RST_POWER_CONTROL   = 8'h00;
  localparam logic [7:0] SMR_RST_OSR_SETUP  = 8'h00;
  localparam logic [7:0] SMR_RST_ODR_SETUP  = 8'h00;
  localparam logic [7:0] SMR_RST_FILT       = 8'h00;

  localparam logic [4:0] SMR_RATE_EXP_MAX   = 5'h11;
  localparam logic [2:0] SMR_OSR_CODE_MAX   = 3'h5;

  // Timing
  localparam longint SMR_CLK_PERIOD_NS   = 10;
  localparam longint SMR_WDT_SHORT_NS    = 1250000;
  localparam longint SMR_WDT_LONG_NS     = 40000000;
  localparam longint SMR_SAMPLE_BASE_NS  = 5000000;
  localparam int SMR_WDT_SHORT_CYC   = int'(SMR_WDT_SHORT_NS / SMR_CLK_PERIOD_NS);
  localparam int SMR_WDT_LONG_CYC    = int'(SMR_WDT_LONG_NS / SMR_CLK_PERIOD_NS);
  localparam int SMR_SAMPLE_BASE_CYC = int'(SMR_SAMPLE_BASE_NS / SMR_CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    SMR_MODE_SLEEP  = 2'b00,
    SMR_MODE_FORCED = 2'b01,
    SMR_MODE_NORMAL = 2'b11
  } smr_mode_e;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smr_req_s;

  typedef struct packed {
    logic data_ready;
    logic fifo_full;
    logic fifo_watermark;
  } smr_events_s;

endpackage

// [src/smr_cfg_decode.sv]
`timescale 1ns/1ns
module smr_cfg_decode
  import smr_pkg::*;
#(
  parameter int SAMPLE_BASE_CYCLES = SMR_SAMPLE_BASE_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] power_control,
  input  wire logic [7:0] osr_setup,
  input  wire logic [7:0] odr_setup,
  input  wire logic [7:0] filt_setup,
  output smr_mode_e       meas_mode,
  output logic [5:0]      pressure_oversample,
  output logic [5:0]      temperature_oversample,
  output logic [35:0]     sample_period_cycles,
  output logic [6:0]      smoothing_coefficient
);

  typedef struct packed {
    smr_mode_e   mode;
    logic [5:0]  p_os;
    logic [5:0]  t_os;
    logic [35:0] period;
    logic [6:0]  coef;
  } smr_dec_s;

  smr_dec_s dec_r;
  smr_dec_s dec_nxt;

  function automatic logic [5:0] os_factor(input logic [2:0] code);
    logic [2:0] c;
    c = (code > SMR_OSR_CODE_MAX) ? SMR_OSR_CODE_MAX : code;
    return 6'(6'h01 << c);
  endfunction

  always_comb begin
    dec_nxt = dec_r;
    case (power_control[SMR_PC_MODE_LO +: 2])
      2'b00:   dec_nxt.mode = SMR_MODE_SLEEP;
      2'b11:   dec_nxt.mode = SMR_MODE_NORMAL;
      default: dec_nxt.mode = SMR_MODE_FORCED;
    endcase
    dec_nxt.p_os   = os_factor(osr_setup[SMR_OS_PRESS_LO +: 3]);
    dec_nxt.t_os   = os_factor(osr_setup[SMR_OS_TEMP_LO +: 3]);
    dec_nxt.period = 36'(36'(SAMPLE_BASE_CYCLES) << odr_setup[4:0]);
    dec_nxt.coef   = 7'((8'h01 << filt_setup[SMR_FC_COEF_LO +: 3]) - 8'h01);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_r <= '0;
    end else begin
      dec_r <= dec_nxt;
    end
  end

  assign meas_mode              = dec_r.mode;
  assign pressure_oversample    = dec_r.p_os;
  assign temperature_oversample = dec_r.t_os;
  assign sample_period_cycles   = dec_r.period;
  assign smoothing_coefficient  = dec_r.coef;

endmodule // smr_cfg_decode

// [src/smr_irq_pin.sv]
`timescale 1ns/1ns
module smr_irq_pin
  import smr_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic irq_active,
  input  wire logic irq_polarity,
  input  wire logic irq_output_drive_type,
  output logic      irq_pin_out,
  output logic      irq_pin_oe
);

  typedef struct packed {
    logic out;
    logic oe;
  } smr_pin_s;

  smr_pin_s pin_r;
  smr_pin_s pin_nxt;
  logic     level;

  always_comb begin
    level   = irq_active ~^ irq_polarity;
    pin_nxt = pin_r;
    if (irq_output_drive_type) begin
      pin_nxt.out = 1'b0;
      pin_nxt.oe  = ~level;
    end else begin
      pin_nxt.out = level;
      pin_nxt.oe  = 1'b1;
    end
  end

  // Idle level of an active-low push-pull pin is high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= '{out: 1'b1, oe: 1'b1};
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign irq_pin_out = pin_r.out;
  assign irq_pin_oe  = pin_r.oe;

endmodule // smr_irq_pin

// [verif/smr_host_model.sv]
`timescale 1ns/1ns
module smr_host_model
  import smr_pkg::*;
(
  input  wire logic       sys_clk,
  output smr_req_s        req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  // Quiet port until the first access
  initial begin
    req = '{1'b0, 1'b0, 8'h00, 8'h00};
  end

  // One write strobe, then address and data are scrambled so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    #1;
    req = '{1'b0, 1'b0, ~a, ~d};
  endtask

  // One read strobe; answer is taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    #1;
    req = '{1'b0, 1'b1, a, ~req.wdata};
    @(posedge sys_clk);
    #1;
    d = rd_data;
    v = rd_valid;
    req = '{1'b0, 1'b0, ~a, ~req.wdata};
  endtask
endmodule // smr_host_model

// [verif/sensor_measurement_config_regs_test.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module sensor_measurement_config_regs_test;
  import smr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n;
  smr_req_s    req;
  logic [7:0]  rd_data;
  logic        rd_valid;
  smr_events_s events;
  logic        nvm_wdt_enable;
  logic        nvm_wdt_period;
  logic        irq_pin_out;
  logic        irq_pin_oe;
  logic        irq_line;
  logic        strength;
  logic        three_wire;
  logic        wdt_en;
  logic [31:0] wdt_cycles;
  logic        press_on;
  logic        temp_on;
  smr_mode_e   meas_mode;
  logic [5:0]  press_os;
  logic [5:0]  temp_os;
  logic [4:0]  rate_exp;
  logic [35:0] period;
  logic [6:0]  coef;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [7:0]  addrs [6] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1F};
  logic [7:0]  rexp  [6] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wexp  [6] = '{8'h7F, 8'h07, 8'h33, 8'h3F, 8'h11, 8'h0E};
  logic [7:0]  odr_v [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h1F};
  logic [7:0]  en_v  [3] = '{8'h08, 8'h10, 8'h40};
  logic [7:0]  fl_v  [3] = '{8'h01, 8'h02, 8'h08};

  // Interrupt line has a pull-up when nobody drives it
  assign irq_line = irq_pin_oe ? irq_pin_out : 1'b1;

  always #5 sys_clk = ~sys_clk;

  smr_config_regs #(
    .WDT_SHORT_CYCLES   (20),
    .WDT_LONG_CYCLES    (40),
    .SAMPLE_BASE_CYCLES (8)
  ) u_dut (
    .sys_clk                (sys_clk),
    .rst_n                  (rst_n),
    .req                    (req),
    .rd_data                (rd_data),
    .rd_valid               (rd_valid),
    .events                 (events),
    .nvm_wdt_enable         (nvm_wdt_enable),
    .nvm_wdt_period         (nvm_wdt_period),
    .irq_pin_out            (irq_pin_out),
    .irq_pin_oe             (irq_pin_oe),
    .irq_pad_strength_sel   (strength),
    .three_wire_select      (three_wire),
    .bus_watchdog_enable    (wdt_en),
    .bus_watchdog_cycles    (wdt_cycles),
    .pressure_channel_on    (press_on),
    .temperature_channel_on (temp_on),
    .meas_mode              (meas_mode),
    .pressure_oversample    (press_os),
    .temperature_oversample (temp_os),
    .rate_divider_exponent  (rate_exp),
    .sample_period_cycles   (period),
    .smoothing_coefficient  (coef)
  );

  smr_host_model u_host (
    .sys_clk  (sys_clk),
    .req      (req),
    .rd_data  (rd_data),
    .rd_valid (rd_valid)
  );

  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic ev(input logic [2:0] v);
    @(posedge sys_clk);
    #1;
    events = v;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    u_host.rd(a, d, v);
    `CHK("rd_valid", 1'b1, v)
    `CHK("rd_data", e, d)
  endtask

  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    logic [4:0] e;
    smr_mode_e  me;
    rst_n = 1'b0;
    events = 3'b000;
    nvm_wdt_enable = 1'b1;
    nvm_wdt_period = 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    idle(2);
    `CHK("wdt_enable", 1'b1, wdt_en)
    `CHK("wdt_cycles", 32'd40, wdt_cycles)
    for (int i = 0; i < 6; i++) rchk(addrs[i], rexp[i]);
    for (int i = 0; i < 6; i++) u_host.wr(addrs[i], 8'hFF);
    idle(2);
    for (int i = 0; i < 6; i++) rchk(addrs[i], wexp[i]);
    `CHK("three_wire", 1'b1, three_wire)
    `CHK("strength", 1'b1, strength)
    u_host.wr(8'h1A, 8'h01);
    idle(2);
    `CHK("wdt_enable", 1'b0, wdt_en)
    `CHK("wdt_cycles", 32'd20, wdt_cycles)
    u_host.wr(8'h1A, 8'h00);
    idle(2);
    `CHK("three_wire", 1'b0, three_wire)
    // Unmapped and read-only places
    u_host.wr(8'h1E, 8'hFF);
    u_host.wr(8'h11, 8'hFF);
    rchk(8'h1E, 8'h00);
    rchk(8'h11, 8'h00);
    for (int m = 0; m < 4; m++) begin
      u_host.wr(8'h1B, 8'((m << 4) | m));
      idle(2);
      me = (m == 0) ? SMR_MODE_SLEEP : (m == 3) ? SMR_MODE_NORMAL : SMR_MODE_FORCED;
      `CHK("meas_mode", me, meas_mode)
      `CHK("press_on", 1'(m), press_on)
      `CHK("temp_on", 1'(m >> 1), temp_on)
    end
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h1C, 8'(((7 - c) << 3) | c));
      idle(2);
      `CHK("press_os", 6'(1 << (c > 5 ? 5 : c)), press_os)
      `CHK("temp_os", 6'(1 << ((7 - c) > 5 ? 5 : 7 - c)), temp_os)
    end
    for (int i = 0; i < 6; i++) begin
      u_host.wr(8'h1D, odr_v[i]);
      idle(2);
      e = (odr_v[i] > 8'h11) ? 5'h11 : odr_v[i][4:0];
      `CHK("rate_exp", e, rate_exp)
      `CHK("period", 36'd8 << e, period)
    end
    for (int c = 0; c < 8; c++) begin
      u_host.wr(8'h1F, 8'(c << 1));
      idle(2);
      `CHK("coef", 7'((1 << c) - 1), coef)
    end
    // Latched flags, push-pull, asserted low, one source enabled at a time
    for (int i = 0; i < 3; i++) begin
      u_host.wr(8'h19, 8'h04 | en_v[i]);
      ev(3'b111);
      ev(3'b000);
      idle(2);
      `CHK("irq_line", 1'b0, irq_line)
      rchk(8'h11, fl_v[i]);
      idle(2);
      `CHK("irq_line", 1'b1, irq_line)
      `CHK("irq_oe", 1'b1, irq_pin_oe)
      rchk(8'h11, 8'h00);
    end
    // Unlatched, asserted high
    u_host.wr(8'h19, 8'h4A);
    ev(3'b001);
    idle(3);
    `CHK("irq_line", 1'b1, irq_line)
    rchk(8'h11, 8'h01);
    ev(3'b000);
    idle(3);
    `CHK("irq_line", 1'b0, irq_line)
    rchk(8'h11, 8'h00);
    // Open-drain, asserted low
    u_host.wr(8'h19, 8'h49);
    ev(3'b100);
    idle(3);
    `CHK("irq_oe", 1'b1, irq_pin_oe)
    `CHK("irq_line", 1'b0, irq_line)
    ev(3'b000);
    idle(3);
    `CHK("irq_oe", 1'b0, irq_pin_oe)
    `CHK("irq_line", 1'b1, irq_line)
    // Second reset with the nonvolatile defaults low
    nvm_wdt_enable = 1'b0;
    nvm_wdt_period = 1'b0;
    rst_n = 1'b0;
    idle(2);
    `CHK("irq_oe", 1'b1, irq_pin_oe)
    `CHK("coef", 7'h00, coef)
    rst_n = 1'b1;
    idle(2);
    `CHK("wdt_enable", 1'b0, wdt_en)
    `CHK("wdt_cycles", 32'd20, wdt_cycles)
    rchk(8'h19, 8'h00);
    rchk(8'h1A, 8'h00);
    results();
  end
endmodule // sensor_measurement_config_regs_test
